// File: pkg/expander_pkg.sv
// Purpose: constants and types shared by the I2C target register block
// Assumes: 8-bit registers, 7-bit target address
// Notes: named constants live here; a few bare literals such as 4'h1 remain in the logic
// What this block does
// - Reset pin low holds the bus engine idle and all registers but the sampled pin levels at defaults.
// - Toggling the reset pin refreshes the sampled pin levels register.
// - General-call address with write direction is acknowledged.
// - General-call address with read direction is not acknowledged.
// - Only data byte 0x06 after general call is acknowledged and arms reset.
// - Extra bytes after general call are refused and cancel the reset.
// - Software reset fires on STOP only; repeated START cancels it.
// - Software reset returns every register except the sampled pin levels to its default.
// - Power-on indication holds reset; release starts everything at defaults.
// - Target address is 0x20 or 0x21, strap gives the low bit.
// - Last address bit is direction: one read, zero write.
// - Address byte is sampled MSB first right after START.
// - Matching address is acknowledged by holding SDA low on ninth clock.
// - SDA changes only with SCL low; SDA edges with SCL high are START/STOP.
// - Every byte received while addressed at the target address is acknowledged.
// - Controller NACKs the last read byte; device then releases SDA.
// - First write byte after address loads the pointer register.
// - Reads keep using the register named by the last command byte.
// - Pointer clears to 0x00 on power-up, hardware and software reset.
// - Codes 0x00-0x03 are base registers; 0x40-0x46 and 0x4F extended.
// - Writes to the sampled pin levels register have no effect.
package expander_pkg;
  localparam logic [6:0] TARGET_BASE = 7'h10; // Upper six bits, strap added
  localparam logic [6:0] GENCALL_ADDR = 7'h00;
  localparam logic [7:0] SWRESET_BYTE = 8'h06;
  localparam logic [7:0] CMD_PIN_LEVEL = 8'h00;
  localparam logic [7:0] CMD_DRIVE_VAL = 8'h01;
  localparam logic [7:0] CMD_INVERT = 8'h02;
  localparam logic [7:0] CMD_DIRECTION = 8'h03;
  localparam logic [7:0] CMD_DRV_LOW = 8'h40;
  localparam logic [7:0] CMD_DRV_HIGH = 8'h41;
  localparam logic [7:0] CMD_HOLD_EN = 8'h42;
  localparam logic [7:0] CMD_BIAS_EN = 8'h43;
  localparam logic [7:0] CMD_BIAS_SEL = 8'h44;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h45;
  localparam logic [7:0] CMD_ALERT_FLAGS = 8'h46;
  localparam logic [7:0] CMD_STAGE_TYPE = 8'h4F;
  localparam logic [7:0] RST_DRIVE_VAL = 8'hFF;
  localparam logic [7:0] RST_INVERT = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_DRV_LOW = 8'hFF;
  localparam logic [7:0] RST_DRV_HIGH = 8'hFF;
  localparam logic [7:0] RST_HOLD_EN = 8'h00;
  localparam logic [7:0] RST_BIAS_EN = 8'h00;
  localparam logic [7:0] RST_BIAS_SEL = 8'hFF;
  localparam logic [7:0] RST_ALERT_MASK = 8'hFF;
  localparam logic [7:0] RST_STAGE_TYPE = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_RX, LK_RX_ACK, LK_TX, LK_TX_ACK, LK_IGNORE
  } link_state_e;
  // Write-to-register event kinds handed from link to core
  typedef enum logic [1:0] {
    EV_NONE, EV_POINTER, EV_DATA
  } link_event_e;
endpackage

// File: rtl/io_expander_i2c_target_regs.sv
// Purpose: I2C target front end and register file of an 8-bit I/O expander
// Assumes: link_clk is the link clock; sda sampled on scl edges, START/STOP
//   detected on sda edges with scl high via oversampling at link_clk
// Notes: link logic runs on link_clk sampling scl/sda through synchronisers;
//   register file on clk; pointer and write data pass as events
`timescale 1ns/1ps
module io_expander_i2c_target_regs
  import expander_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic addr_strap,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [DATA_W-1:0] port_pin_level,
  input wire logic [DATA_W-1:0] change_alert_src,
  output logic [DATA_W-1:0] pin_drive_value,
  output logic [DATA_W-1:0] input_invert,
  output logic [DATA_W-1:0] pin_direction,
  output logic [DATA_W-1:0] drive_level_low_pins,
  output logic [DATA_W-1:0] drive_level_high_pins,
  output logic [DATA_W-1:0] input_hold_enable,
  output logic [DATA_W-1:0] bias_resistor_enable,
  output logic [DATA_W-1:0] bias_resistor_select,
  output logic [DATA_W-1:0] change_alert_mask,
  output logic [DATA_W-1:0] output_stage_type,
  output logic [DATA_W-1:0] pin_level_sample
);
  import expander_pkg::*;

  if (DATA_W != 8) begin
    $error("register width must be 8");
  end
  // Link domain: bus engine on link_clk
  typedef struct packed {
    logic scl_d_r;
    logic sda_d_r;
    link_state_e st_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic rd_r;
    logic gencall_r;
    logic first_r;
    logic armed_r;
    logic drive_low_r;
    logic sw_reset_tog_r;
    logic [7:0] tx_r;
  } link_s;
  link_s lk_r;
  link_s lk_nxt;
  logic scl_s, sda_s, strap_s, rstpin_s, ev_valid;
  logic [9:0] ev_word;
  logic [9:0] ev_word_c;
  logic [7:0] rd_data_l;
  sync_level #(.WIDTH(4), .RESET_VAL(1'b1)) u_link_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({scl_in, sda_in, addr_strap, reset_pin_n}),
    .q({scl_s, sda_s, strap_s, rstpin_s})
  );

  logic scl_rise, scl_fall, start_c, stop_c, ev_fire;
  logic [7:0] rx_byte;
  logic [1:0] ev_kind;
  assign scl_rise = scl_s & ~lk_r.scl_d_r;
  assign scl_fall = ~scl_s & lk_r.scl_d_r;
  assign start_c = scl_s & lk_r.scl_d_r & lk_r.sda_d_r & ~sda_s;
  assign stop_c = scl_s & lk_r.scl_d_r & ~lk_r.sda_d_r & sda_s;
  assign rx_byte = {lk_r.shift_r[6:0], sda_s};

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.scl_d_r = scl_s;
    lk_nxt.sda_d_r = sda_s;
    ev_kind = EV_NONE;
    ev_fire = 1'b0;
    if (!rstpin_s) begin
      lk_nxt.st_r = LK_IDLE;
      lk_nxt.drive_low_r = 1'b0;
      lk_nxt.armed_r = 1'b0;
    end else if (start_c) begin
      lk_nxt.st_r = LK_ADDR;
      lk_nxt.bit_r = '0;
      lk_nxt.armed_r = 1'b0;
      lk_nxt.drive_low_r = 1'b0;
    end else if (stop_c) begin
      if (lk_r.armed_r) begin
        lk_nxt.sw_reset_tog_r = ~lk_r.sw_reset_tog_r;
      end
      lk_nxt.armed_r = 1'b0;
      lk_nxt.st_r = LK_IDLE;
      lk_nxt.drive_low_r = 1'b0;
    end else begin
      unique case (lk_r.st_r)
        LK_IDLE, LK_IGNORE: begin
          lk_nxt.drive_low_r = 1'b0;
        end
        LK_ADDR, LK_RX: begin
          if (scl_rise) begin
            lk_nxt.shift_r = rx_byte;
            lk_nxt.bit_r = lk_r.bit_r + 4'h1;
          end
          if (scl_fall && lk_r.bit_r == BITS_PER_BYTE) begin
            lk_nxt.bit_r = '0;
            if (lk_r.st_r == LK_ADDR) begin
              lk_nxt.rd_r = lk_r.shift_r[0];
              lk_nxt.first_r = 1'b1;
              if (lk_r.shift_r[7:1] == (TARGET_BASE << 1 | {6'h00, strap_s})) begin
                lk_nxt.gencall_r = 1'b0;
                lk_nxt.st_r = LK_ADDR_ACK;
                lk_nxt.drive_low_r = 1'b1;
              end else if (lk_r.shift_r[7:1] == GENCALL_ADDR && !lk_r.shift_r[0]) begin
                lk_nxt.gencall_r = 1'b1;
                lk_nxt.st_r = LK_ADDR_ACK;
                lk_nxt.drive_low_r = 1'b1;
              end else begin
                lk_nxt.st_r = LK_IGNORE;
              end
            end else if (lk_r.gencall_r) begin
              if (lk_r.first_r && lk_r.shift_r == SWRESET_BYTE) begin
                lk_nxt.armed_r = 1'b1;
                lk_nxt.drive_low_r = 1'b1;
                lk_nxt.first_r = 1'b0;
                lk_nxt.st_r = LK_RX_ACK;
              end else begin
                lk_nxt.armed_r = 1'b0;
                lk_nxt.st_r = LK_IGNORE;
              end
            end else begin
              lk_nxt.drive_low_r = 1'b1;
              lk_nxt.st_r = LK_RX_ACK;
              ev_fire = 1'b1;
              ev_kind = lk_r.first_r ? EV_POINTER : EV_DATA;
              lk_nxt.first_r = 1'b0;
            end
          end
        end
        LK_ADDR_ACK, LK_RX_ACK: begin
          if (scl_fall) begin
            lk_nxt.drive_low_r = 1'b0;
            if (lk_r.st_r == LK_ADDR_ACK && lk_r.rd_r) begin
              lk_nxt.st_r = LK_TX;
              lk_nxt.tx_r = rd_data_l;
              lk_nxt.drive_low_r = ~rd_data_l[7];
              lk_nxt.bit_r = 4'h1;
            end else begin
              lk_nxt.st_r = LK_RX;
            end
          end
        end
        LK_TX: begin
          if (scl_fall) begin
            if (lk_r.bit_r == BITS_PER_BYTE) begin
              lk_nxt.drive_low_r = 1'b0;
              lk_nxt.st_r = LK_TX_ACK;
            end else begin
              lk_nxt.tx_r = {lk_r.tx_r[6:0], 1'b0};
              lk_nxt.drive_low_r = ~lk_r.tx_r[6];
              lk_nxt.bit_r = lk_r.bit_r + 4'h1;
            end
          end
        end
        LK_TX_ACK: begin
          if (scl_rise) begin
            lk_nxt.rd_r = ~sda_s; // Controller ack means continue
          end
          if (scl_fall) begin
            if (lk_r.rd_r) begin
              lk_nxt.st_r = LK_TX;
              lk_nxt.tx_r = rd_data_l;
              lk_nxt.drive_low_r = ~rd_data_l[7];
              lk_nxt.bit_r = 4'h1;
            end else begin
              lk_nxt.st_r = LK_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk_r <= '{scl_d_r: 1'b1, sda_d_r: 1'b1, st_r: LK_IDLE, default: '0};
    end else begin
      lk_r <= lk_nxt;
    end
  end
  // Finished byte, held in the shifter, crosses with its kind
  assign ev_word = {ev_kind, lk_r.shift_r};
  assign sda_out = 1'b0;
  assign sda_oe = lk_r.drive_low_r;
  // Register domain on clk
  typedef struct packed {
    logic [7:0] pointer_r;
    logic [7:0] drive_val_r;
    logic [7:0] invert_r;
    logic [7:0] direction_r;
    logic [7:0] drv_low_r;
    logic [7:0] drv_high_r;
    logic [7:0] hold_en_r;
    logic [7:0] bias_en_r;
    logic [7:0] bias_sel_r;
    logic [7:0] alert_mask_r;
    logic [7:0] stage_type_r;
    logic [7:0] sample_r;
    logic rstpin_d_r;
    logic [7:0] rd_data_r;
    logic swrst_seen_r;
  } core_s;
  core_s cr_r;
  core_s cr_nxt;
  logic rstpin_c, swrst_ev, swrst_tog_c;
  logic [7:0] pins_c, alert_c;
  sync_level #(.WIDTH(1), .RESET_VAL(1'b1)) u_rst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(reset_pin_n),
    .q(rstpin_c)
  );
  sync_level #(.WIDTH(16), .RESET_VAL(1'b0)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({port_pin_level, change_alert_src}),
    .q({pins_c, alert_c})
  );

  toggle_xfer #(.WIDTH(10)) u_byte_xfer (
    .src_clk(link_clk),
    .src_rst_n(link_rst_n),
    .src_event(ev_fire),
    .src_data(ev_word),
    .dst_clk(clk),
    .dst_rst_n(rst_n),
    .dst_event(ev_valid),
    .dst_data(ev_word_c)
  );
  // Software reset travels as the toggle itself, synchronised
  sync_level #(.WIDTH(1), .RESET_VAL(1'b0)) u_swrst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(lk_r.sw_reset_tog_r),
    .q(swrst_tog_c)
  );
  assign swrst_ev = swrst_tog_c ^ cr_r.swrst_seen_r;
  // Read data back to link: register at the pointer, updated every clk cycle
  sync_level #(.WIDTH(8), .RESET_VAL(1'b0)) u_rd_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(cr_r.rd_data_r),
    .q(rd_data_l)
  );

  function automatic logic [7:0] reg_read(input core_s c, input logic [7:0] alert);
    unique case (c.pointer_r)
      CMD_PIN_LEVEL: reg_read = c.sample_r ^ c.invert_r;
      CMD_DRIVE_VAL: reg_read = c.drive_val_r;
      CMD_INVERT: reg_read = c.invert_r;
      CMD_DIRECTION: reg_read = c.direction_r;
      CMD_DRV_LOW: reg_read = c.drv_low_r;
      CMD_DRV_HIGH: reg_read = c.drv_high_r;
      CMD_HOLD_EN: reg_read = c.hold_en_r;
      CMD_BIAS_EN: reg_read = c.bias_en_r;
      CMD_BIAS_SEL: reg_read = c.bias_sel_r;
      CMD_ALERT_MASK: reg_read = c.alert_mask_r;
      CMD_ALERT_FLAGS: reg_read = alert;
      CMD_STAGE_TYPE: reg_read = c.stage_type_r;
      default: reg_read = 8'h00;
    endcase
  endfunction

  localparam core_s CORE_DEFAULT = '{
    pointer_r: RST_POINTER, drive_val_r: RST_DRIVE_VAL, invert_r: RST_INVERT,
    direction_r: RST_DIRECTION, drv_low_r: RST_DRV_LOW, drv_high_r: RST_DRV_HIGH,
    hold_en_r: RST_HOLD_EN, bias_en_r: RST_BIAS_EN, bias_sel_r: RST_BIAS_SEL,
    alert_mask_r: RST_ALERT_MASK, stage_type_r: RST_STAGE_TYPE, sample_r: 8'h00,
    rstpin_d_r: 1'b1, rd_data_r: 8'h00, swrst_seen_r: 1'b0
  };

  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.rstpin_d_r = rstpin_c;
    cr_nxt.sample_r = pins_c;
    cr_nxt.swrst_seen_r = swrst_tog_c;
    if (!rstpin_c || swrst_ev) begin
      cr_nxt = CORE_DEFAULT;
      cr_nxt.rstpin_d_r = rstpin_c;
      cr_nxt.sample_r = pins_c;
      cr_nxt.swrst_seen_r = swrst_tog_c;
    end else if (ev_valid) begin
      if (ev_word_c[9:8] == EV_POINTER) begin
        cr_nxt.pointer_r = ev_word_c[7:0];
      end else begin
        unique case (cr_r.pointer_r)
          CMD_DRIVE_VAL: cr_nxt.drive_val_r = ev_word_c[7:0];
          CMD_INVERT: cr_nxt.invert_r = ev_word_c[7:0];
          CMD_DIRECTION: cr_nxt.direction_r = ev_word_c[7:0];
          CMD_DRV_LOW: cr_nxt.drv_low_r = ev_word_c[7:0];
          CMD_DRV_HIGH: cr_nxt.drv_high_r = ev_word_c[7:0];
          CMD_HOLD_EN: cr_nxt.hold_en_r = ev_word_c[7:0];
          CMD_BIAS_EN: cr_nxt.bias_en_r = ev_word_c[7:0];
          CMD_BIAS_SEL: cr_nxt.bias_sel_r = ev_word_c[7:0];
          CMD_ALERT_MASK: cr_nxt.alert_mask_r = ev_word_c[7:0];
          CMD_STAGE_TYPE: cr_nxt.stage_type_r = ev_word_c[7:0];
          default: cr_nxt.pointer_r = cr_r.pointer_r;
        endcase
      end
    end
    cr_nxt.rd_data_r = reg_read(cr_nxt, alert_c);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cr_r <= CORE_DEFAULT;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  assign pin_drive_value = cr_r.drive_val_r;
  assign input_invert = cr_r.invert_r;
  assign pin_direction = cr_r.direction_r;
  assign drive_level_low_pins = cr_r.drv_low_r;
  assign drive_level_high_pins = cr_r.drv_high_r;
  assign input_hold_enable = cr_r.hold_en_r;
  assign bias_resistor_enable = cr_r.bias_en_r;
  assign bias_resistor_select = cr_r.bias_sel_r;
  assign change_alert_mask = cr_r.alert_mask_r;
  assign output_stage_type = cr_r.stage_type_r;
  assign pin_level_sample = cr_r.sample_r;

  // Assertions, register domain
  reset_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rstpin_c |=> cr_r.pointer_r == RST_POINTER && cr_r.direction_r == RST_DIRECTION)
    else $error("reset pin did not clear registers");
  sw_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    swrst_ev |=> cr_r.drive_val_r == RST_DRIVE_VAL && cr_r.alert_mask_r == RST_ALERT_MASK)
    else $error("software reset did not restore defaults");
  pointer_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    rstpin_c && !swrst_ev && ev_valid && ev_word_c[9:8] == EV_POINTER |=> cr_r.pointer_r == $past(ev_word_c[7:0]))
    else $error("command byte not stored in pointer");
  pointer_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    rstpin_c && !swrst_ev && ev_valid && ev_word_c[9:8] == EV_DATA |=> $stable(cr_r.pointer_r))
    else $error("pointer advanced on data byte");
  ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    rstpin_c && !swrst_ev && ev_valid && ev_word_c[9:8] == EV_DATA && cr_r.pointer_r == CMD_ALERT_FLAGS
    |=> $stable(cr_r.drive_val_r) && $stable(cr_r.invert_r))
    else $error("write to read-only code changed a register");
  // Assertions, link domain
  addr_ack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    lk_r.st_r == LK_ADDR_ACK && !scl_fall && !start_c && !stop_c && rstpin_s |=> lk_r.drive_low_r)
    else $error("address ack released early");
  gencall_read_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    lk_r.st_r == LK_ADDR && scl_fall && lk_r.bit_r == BITS_PER_BYTE && lk_r.shift_r == 8'h01 && rstpin_s
    && !start_c && !stop_c |=> !lk_r.drive_low_r)
    else $error("general call read was acknowledged");
  start_addr_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    rstpin_s && start_c |=> lk_r.st_r == LK_ADDR && lk_r.bit_r == 4'h0 && !lk_r.armed_r)
    else $error("START did not restart address phase");
endmodule

// File: rtl/sync_level.sv
// Purpose: two-flop synchroniser for levels, WIDTH bits each synchronised alone
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sync_level #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  if (WIDTH < 1) begin
    $error("sync_level width must be positive");
  end

  always_comb begin
    st_nxt.meta_r = d;
    st_nxt.q_r = st_r.meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {2*WIDTH{RESET_VAL}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q_r;
endmodule

// File: rtl/toggle_xfer.sv
// Purpose: carries events and a data word from one clock to another
// Assumes: source holds data stable until next event; events sparse
// Notes: toggle crossing; event pulse appears one cycle after sync
`timescale 1ns/1ps
module toggle_xfer #(
  parameter int WIDTH = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_event,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_event,
  output logic [WIDTH-1:0] dst_data
);
  typedef struct packed {
    logic tog_r;
    logic [WIDTH-1:0] data_r;
  } src_s;
  typedef struct packed {
    logic seen_r;
    logic event_r;
    logic [WIDTH-1:0] data_r;
  } dst_s;
  src_s s_r;
  src_s s_nxt;
  dst_s d_r;
  dst_s d_nxt;
  logic tog_sync;

  if (WIDTH < 1) begin
    $error("toggle_xfer width must be positive");
  end

  always_comb begin
    s_nxt = s_r;
    if (src_event) begin
      s_nxt.tog_r = ~s_r.tog_r;
      s_nxt.data_r = src_data;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  sync_level #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync (
    .clk(dst_clk),
    .rst_n(dst_rst_n),
    .d(s_r.tog_r),
    .q(tog_sync)
  );

  always_comb begin
    d_nxt = d_r;
    d_nxt.seen_r = tog_sync;
    d_nxt.event_r = tog_sync ^ d_r.seen_r;
    // Data held stable by source since toggle, safe to take now
    if (tog_sync ^ d_r.seen_r) begin
      d_nxt.data_r = s_r.data_r;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign dst_event = d_r.event_r;
  assign dst_data = d_r.data_r;
endmodule

// File: testbench/i2c_host.sv
// Purpose: bus controller model for the expander target
// Assumes: sda_line is the wired level with pull-up
// Notes: one quarter bit is Q clk cycles
`timescale 1ns/1ps
module i2c_host #(
  parameter int Q = 8
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic q();
    repeat (Q) @(negedge clk);
  endtask
  // Also serves as repeated start
  task automatic start();
    q();
    sda_pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  // Data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_pull = ~b;
    q();
    scl = 1'b1;
    q();
    s = sda_line;
    q();
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, s);
  endtask
endmodule

// File: testbench/io_expander_i2c_target_regs_tb.sv
// Purpose: register and protocol tests over the bus
// Assumes: rst_n serves both clock domains
// Notes: register outputs other than pin_level_sample compared as one packed word
`timescale 1ns/1ps
module io_expander_i2c_target_regs_tb;
  import expander_pkg::*;
  logic clk, link_clk, rst_n, reset_pin_n, addr_strap;
  logic scl, sda_pull, sda_out, sda_oe;
  logic [7:0] pins, alert, d, smp;
  logic [7:0] r1, r2, r3, r40, r41, r42, r43, r44, r45, r4f;
  int n_fail, samples_checked;
  logic [7:0] codes[10] = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h4F};
  localparam logic [79:0] DEF = 80'hFF00FFFFFF0000FFFF00;
  localparam logic [79:0] WR = 80'hA4A7A6E5E4E7E6E1E0EA;
  wire [79:0] regs = {r1, r2, r3, r40, r41, r42, r43, r44, r45, r4f};
  wire sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);
  wire [7:0] aw = {6'h10, addr_strap, 1'b0};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  io_expander_i2c_target_regs DUT (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .addr_strap(addr_strap), .link_clk(link_clk), .link_rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .port_pin_level(pins),
    .change_alert_src(alert), .pin_drive_value(r1), .input_invert(r2), .pin_direction(r3),
    .drive_level_low_pins(r40), .drive_level_high_pins(r41), .input_hold_enable(r42),
    .bias_resistor_enable(r43), .bias_resistor_select(r44), .change_alert_mask(r45),
    .output_stage_type(r4f), .pin_level_sample(smp));
  i2c_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic sb(input logic [7:0] b, input logic e);
    logic k;
    host.wbyte(b, k);
    chk("ack", 80'(e), 80'(k));
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    host.start();
    sb(aw, 1'b1);
    sb(c, 1'b1);
    sb(v, 1'b1);
    host.stop();
  endtask
  // Read at the current pointer, two bytes
  task automatic rp(input logic [7:0] e);
    host.start();
    sb(aw | 8'h01, 1'b1);
    host.rbyte(1'b0, d);
    chk("read", 80'(e), 80'(d));
    host.rbyte(1'b1, d);
    chk("read again", 80'(e), 80'(d));
    host.stop();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    host.start();
    sb(aw, 1'b1);
    sb(c, 1'b1);
    host.stop();
    rp(e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    addr_strap = 1'b0;
    pins = 8'h5A;
    alert = 8'h3C;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("defaults", DEF, regs);
    rp(8'h5A);
    foreach (codes[i]) begin
      wr(codes[i], codes[i] ^ 8'hA5);
      rd(codes[i], codes[i] ^ 8'hA5);
    end
    chk("written", WR, regs);
    wr(8'h00, 8'h33);
    wr(8'h10, 8'h33);
    wr(8'h46, 8'h33);
    chk("read only", WR, regs);
    rd(8'h10, 8'h00);
    rd(8'h00, 8'h5A ^ 8'hA7);
    rd(8'h46, 8'h3C);
    host.start();
    sb(8'h44, 1'b0);
    host.stop();
    addr_strap = 1'b1;
    rd(8'h01, 8'hA4);
    host.start();
    sb(8'h40, 1'b0);
    host.stop();
    addr_strap = 1'b0;
    host.start();
    sb(8'h01, 1'b0);
    host.stop();
    host.start();
    sb(8'h00, 1'b1);
    sb(8'h07, 1'b0);
    host.stop();
    host.start();
    sb(8'h00, 1'b1);
    sb(8'h06, 1'b1);
    sb(8'h06, 1'b0);
    host.stop();
    host.start();
    sb(8'h00, 1'b1);
    sb(8'h06, 1'b1);
    wr(8'h01, 8'hA4);
    repeat (10) @(negedge clk);
    chk("no reset", WR, regs);
    host.start();
    sb(8'h00, 1'b1);
    sb(8'h06, 1'b1);
    host.stop();
    repeat (10) @(negedge clk);
    chk("soft reset", DEF, regs);
    rp(8'h5A);
    wr(8'h02, 8'hFF);
    pins = 8'hC3;
    reset_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    chk("pin reset", DEF, regs);
    chk("sample", 80'(8'hC3), 80'(smp));
    reset_pin_n = 1'b1;
    repeat (10) @(negedge clk);
    rp(8'hC3);
    conclude();
  end
endmodule
